// >>> hdl/epc_pkg.sv
// package for the eprom programming controller
package epc_pkg;
    // register byte offsets on the wishbone side
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h4;
    localparam logic [3:0] REG_DATA   = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    // control field positions
    localparam int CTRL_GO_BIT    = 0;
    localparam int CTRL_OP_LSB    = 1;
    localparam int CTRL_OP_W      = 2;
    // status field positions
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_DONE_BIT    = 1;
    localparam int ST_FAIL_BIT    = 2;
    localparam int ST_PCNT_LSB    = 8;
    localparam int ST_RDATA_LSB   = 16;
    // memory geometry
    localparam int ADDR_W         = 13;
    localparam int DATA_W         = 8;
    localparam int ID_CODE_BIT    = 0;
    localparam logic [7:0] ERASED_WORD = 8'hff;
    // timing
    localparam int CLK_HZ         = 25_000_000;
    localparam int PULSE_US       = 500;
    localparam int PULSE_CYC      = PULSE_US * (CLK_HZ / 1_000_000);
    localparam int MAX_PULSES     = 20;
    localparam int TOTAL_MS       = 10;
    localparam int ACCESS_NS      = 300;
    localparam int ACCESS_CYC     = (ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SUPPLY_US      = 2;
    localparam int SUPPLY_CYC     = SUPPLY_US * (CLK_HZ / 1_000_000);
    localparam int SETUP_CYC      = 2;
    localparam int TMR_W          = 16;
    // operations
    typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_ID_MAKER, OP_ID_TYPE} epc_op_t;
    // pin bundle toward the memory
    typedef struct packed {
        logic              selectN;
        logic              gateN;
        logic              program_strobe_n;
        logic              vppHigh;
        logic              vccHigh;
        logic              id_access_address_pin;
        logic [ADDR_W-1:0] addr;
    } epc_pins_t;
    typedef struct packed {
        logic              busy;
        logic              done;
        logic              fail;
        logic [4:0]        pulses;
        logic [DATA_W-1:0] rdata;
    } epc_stat_t;
endpackage

// >>> hdl/epc_sync.sv
// three stage synchroniser for the data pins
`timescale 1ns/1ps
`default_nettype none
module epc_sync
    import epc_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // pins
    input  wire logic [DATA_W-1:0] din,
    output logic      [DATA_W-1:0] dout
);
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s1   <= '0;
            s2   <= '0;
            s3   <= '0;
            dout <= '0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                dout <= s3;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/epc_timer.sv
// down counter for pin timing
`timescale 1ns/1ps
`default_nettype none
module epc_timer
    import epc_pkg::*;
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // control
    input  wire logic             load,
    input  wire logic [TMR_W-1:0] count,
    output logic                  expired
);
    logic [TMR_W-1:0] remain;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            remain <= '0;
        else if (load)
            remain <= count;
        else if (remain != '0)
            remain <= remain - 1'b1;
    end

    assign expired = (remain == '0) && !load;
endmodule
`default_nettype wire

// >>> hdl/epc_ctrl.sv
// eprom read, identification and pulse-and-verify programming controller
//
// Notes on behaviour
// - read only with select and gate low; program strobe stays high.
// - after a supply sag, change the address before trusting data.
// - high supplies in program, verify, inhibit; normal otherwise.
// - controller drives the eight data bits during programming.
// - select stays low whole time programming supply is raised.
// - each strobe pulse only after address and data settle.
// - repeat 0.5 ms pulses until verify, at most 20 or 10 ms.
// - never a static strobe low; discrete pulses only.
// - verify follows each pulse; supply returns to normal afterwards.
// - id pin raised, others low, code select picks the byte.
// - select decoded per device, gate shared from read strobe.
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module epc_ctrl
    import epc_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // memory pins
    output epc_pins_t              pins,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe
);
    typedef enum {
        S_IDLE, S_SUPPLY_UP, S_SETUP, S_PULSE, S_RECOVER, S_VERIFY, S_SUPPLY_DOWN,
        S_READ, S_FINISH
    } epc_state_t;

    epc_state_t        state;
    epc_op_t           op;
    logic [ADDR_W-1:0] addrReg;
    logic [DATA_W-1:0] wordReg;
    epc_stat_t         stat;
    logic              goPulse;
    logic              tmrLoad;
    logic [TMR_W-1:0]  tmrCount;
    logic              tmrDone;
    logic [DATA_W-1:0] dataSync;
    logic              wbHit;
    logic              next_strobeN;

    function automatic logic [TMR_W-1:0] cyc(input int n);
        cyc = TMR_W'(n);
    endfunction

    function automatic logic isIdOp(input epc_op_t o);
        isIdOp = (o == OP_ID_MAKER) || (o == OP_ID_TYPE);
    endfunction

    function automatic logic pulseLimit(input logic [4:0] n);
        pulseLimit = (32'(n) >= MAX_PULSES);
    endfunction

    epc_sync u_sync
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (data_in),
        .dout    (dataSync)
    );

    epc_timer u_timer
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .load    (tmrLoad),
        .count   (tmrCount),
        .expired (tmrDone)
    );

    // ========================================================
    // wishbone register access
    assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= wbHit;
            if (wbHit && !wb_we_i)
            begin
                case (wb_adr_i)
                    REG_CTRL:   wb_dat_o <= {29'h0, op, 1'b0};
                    REG_ADDR:   wb_dat_o <= {19'h0, addrReg};
                    REG_DATA:   wb_dat_o <= {24'h0, wordReg};
                    REG_STATUS: wb_dat_o <= {8'h0, stat.rdata, 3'h0, stat.pulses,
                                             5'h0, stat.fail, stat.done, stat.busy};
                    default:    wb_dat_o <= '0;
                endcase
            end
        end
    end

    // writes are refused while busy so the pins never change mid operation
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            op      <= OP_READ;
            addrReg <= '0;
            wordReg <= ERASED_WORD;
            goPulse <= 1'b0;
        end
        else
        begin
            goPulse <= 1'b0;
            if (wbHit && wb_we_i && !stat.busy && wb_sel_i[0])
            begin
                case (wb_adr_i)
                    REG_CTRL:
                    begin
                        op      <= epc_op_t'(wb_dat_i[CTRL_OP_LSB +: CTRL_OP_W]);
                        goPulse <= wb_dat_i[CTRL_GO_BIT];
                    end
                    REG_ADDR:
                    begin
                        addrReg[7:0] <= wb_dat_i[7:0];
                        if (wb_sel_i[1])
                            addrReg[ADDR_W-1:8] <= wb_dat_i[ADDR_W-1:8];
                    end
                    REG_DATA: wordReg <= wb_dat_i[DATA_W-1:0];
                    default:  ;
                endcase
            end
        end
    end

    // ========================================================
    // sequencer
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state    <= S_IDLE;
            tmrLoad  <= 1'b0;
            tmrCount <= '0;
            stat     <= '0;
        end
        else
        begin
            tmrLoad <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (goPulse)
                    begin
                        stat.busy   <= 1'b1;
                        stat.done   <= 1'b0;
                        stat.fail   <= 1'b0;
                        stat.pulses <= '0;
                        tmrLoad     <= 1'b1;
                        if (op == OP_PROGRAM)
                        begin
                            tmrCount <= cyc(SUPPLY_CYC);
                            state    <= S_SUPPLY_UP;
                        end
                        else
                        begin
                            tmrCount <= cyc(ACCESS_CYC + 3);
                            state    <= S_READ;
                        end
                    end
                end
                S_SUPPLY_UP:
                    if (tmrDone)
                    begin
                        tmrLoad  <= 1'b1;
                        tmrCount <= cyc(SETUP_CYC);
                        state    <= S_SETUP;
                    end
                S_SETUP:
                    if (tmrDone)
                    begin
                        tmrLoad     <= 1'b1;
                        // the timer load cycle also holds the strobe low, so one count less
                        tmrCount    <= cyc(PULSE_CYC - 1);
                        stat.pulses <= stat.pulses + 1'b1;
                        state       <= S_PULSE;
                    end
                S_PULSE:
                    if (tmrDone)
                    begin
                        tmrLoad  <= 1'b1;
                        tmrCount <= cyc(SETUP_CYC);
                        state    <= S_RECOVER;
                    end
                S_RECOVER:
                    if (tmrDone)
                    begin
                        tmrLoad  <= 1'b1;
                        // three extra cycles cover the data pin synchroniser
                        tmrCount <= cyc(ACCESS_CYC + 3);
                        state    <= S_VERIFY;
                    end
                S_VERIFY:
                    if (tmrDone)
                    begin
                        stat.rdata <= dataSync;
                        // a match or the pulse limit ends the location, else pulse again
                        if (dataSync == wordReg)
                        begin
                            tmrLoad  <= 1'b1;
                            tmrCount <= cyc(SUPPLY_CYC);
                            state    <= S_SUPPLY_DOWN;
                        end
                        else if (pulseLimit(stat.pulses))
                        begin
                            stat.fail <= 1'b1;
                            tmrLoad   <= 1'b1;
                            tmrCount  <= cyc(SUPPLY_CYC);
                            state     <= S_SUPPLY_DOWN;
                        end
                        else
                        begin
                            tmrLoad  <= 1'b1;
                            tmrCount <= cyc(SETUP_CYC);
                            state    <= S_SETUP;
                        end
                    end
                S_SUPPLY_DOWN:
                    if (tmrDone)
                        state <= S_FINISH;
                S_READ:
                    if (tmrDone)
                    begin
                        stat.rdata <= dataSync;
                        state      <= S_FINISH;
                    end
                S_FINISH:
                begin
                    stat.busy <= 1'b0;
                    stat.done <= 1'b1;
                    state     <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ========================================================
    // strobe is low only for the counted part of the pulse state
    always_comb
    begin
        next_strobeN = !(state == S_PULSE && !tmrDone);
    end

    // ========================================================
    // pin drive, all registered
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pins.selectN               <= 1'b1;
            pins.gateN                 <= 1'b1;
            pins.program_strobe_n      <= 1'b1;
            pins.vppHigh               <= 1'b0;
            pins.vccHigh               <= 1'b0;
            pins.id_access_address_pin <= 1'b0;
            pins.addr                  <= '0;
            data_out                   <= ERASED_WORD;
            data_oe                    <= 1'b0;
        end
        else
        begin
            pins.program_strobe_n <= next_strobeN;
            case (state)
                S_READ:
                begin
                    pins.selectN <= 1'b0;
                    pins.gateN   <= 1'b0;
                    pins.id_access_address_pin <= isIdOp(op);
                    if (isIdOp(op))
                    begin
                        pins.addr              <= '0;
                        pins.addr[ID_CODE_BIT] <= (op == OP_ID_TYPE);
                    end
                    else
                        pins.addr <= addrReg;
                    data_oe <= 1'b0;
                end
                S_SUPPLY_UP, S_SETUP, S_PULSE, S_RECOVER:
                begin
                    pins.selectN <= 1'b0;
                    pins.gateN   <= 1'b1;
                    pins.id_access_address_pin <= 1'b0;
                    pins.vppHigh <= 1'b1;
                    pins.vccHigh <= 1'b1;
                    pins.addr    <= addrReg;
                    data_out     <= wordReg;
                    data_oe      <= (state != S_SUPPLY_UP);
                end
                S_VERIFY:
                begin
                    pins.selectN <= 1'b0;
                    pins.gateN   <= 1'b0;
                    pins.addr    <= addrReg;
                    data_oe      <= 1'b0;
                end
                S_SUPPLY_DOWN:
                begin
                    pins.selectN <= 1'b0;
                    pins.gateN   <= 1'b1;
                    pins.vppHigh <= 1'b0;
                    pins.vccHigh <= 1'b0;
                    data_oe      <= 1'b0;
                end
                default:
                begin
                    pins.selectN               <= 1'b1;
                    pins.gateN                 <= 1'b1;
                    pins.id_access_address_pin <= 1'b0;
                    data_oe                    <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> testbench/epc_ctrl_assertions.sv
// concurrent checks on the eprom controller ports
`timescale 1ns/1ps
`default_nettype none
module epc_ctrl_assertions
    import epc_pkg::*;
(
    // clock and reset
    input wire logic      ref_clk,
    input wire logic      rst,
    // wishbone
    input wire logic      wb_cyc_i,
    input wire logic      wb_stb_i,
    input wire logic      wb_ack_o,
    // memory pins
    input wire epc_pins_t pins,
    input wire logic      data_oe
);
    // ==========================================
    // strobe low time counter
    logic [TMR_W-1:0] lowCnt;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            lowCnt <= '0;
        else if (!pins.program_strobe_n)
            lowCnt <= lowCnt + 1'b1;
        else
            lowCnt <= '0;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ==========================================
    // assertions
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_strobe_mode: assert property (!pins.program_strobe_n |-> pins.vppHigh && pins.gateN)
        else $error("strobe low outside program mode");
    a_select_held: assert property (pins.vppHigh |-> !pins.selectN)
        else $error("select high while programming supply raised");
    a_supply_pair: assert property (pins.vppHigh |-> pins.vccHigh)
        else $error("programming supply raised without main supply");
    a_gate_read: assert property (!pins.gateN |-> pins.program_strobe_n && !pins.selectN)
        else $error("gate low without select or with strobe low");
    a_drive_strobe: assert property (!pins.program_strobe_n |-> data_oe)
        else $error("data not driven during strobe");
    a_no_contention: assert property (data_oe |-> pins.gateN)
        else $error("data driven while memory outputs gated on");
    a_pulse_len: assert property ($rose(pins.program_strobe_n) |-> lowCnt == PULSE_CYC)
        else $error("strobe pulse length wrong");
    a_no_static: assert property (lowCnt <= PULSE_CYC)
        else $error("strobe held low too long");
    a_id_lines: assert property (pins.id_access_address_pin |->
        pins.addr[ADDR_W-1:1] == '0 && !pins.gateN && !pins.selectN && !pins.vppHigh)
        else $error("identification read with wrong address or control levels");

    c_pulse: cover property ($rose(pins.program_strobe_n));
    c_id_read: cover property (pins.id_access_address_pin && !pins.gateN);
    c_mem_read: cover property (!pins.gateN && !pins.vppHigh);
endmodule

bind epc_ctrl epc_ctrl_assertions u_chk (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_ack_o (wb_ack_o),
    .pins     (pins),
    .data_oe  (data_oe)
);
`default_nettype wire

// >>> testbench/epc_mem_model.sv
// behavioural model of the 8k x 8 eprom on the controller pins
`timescale 1ns/1ps
`default_nettype none
module epc_mem_model
    import epc_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] TYPE_CODE  = 8'h3c  // arbitrary value
)
(
    // clock for the floating pattern
    input  wire logic              ref_clk,
    // pins from the controller
    input  wire epc_pins_t         pins,
    input  wire logic [DATA_W-1:0] dataOut,
    input  wire logic              dataOe,
    // pulses a location needs before it takes
    input  wire logic [4:0]        needPulses,
    // resolved data line
    output logic      [DATA_W-1:0] dataLine
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] lastVal;
    logic [DATA_W-1:0] progData;
    logic [ADDR_W-1:0] pulseAddr;
    logic [4:0]        pulseCnt;
    logic              driving;

    initial
    begin
        foreach (mem[i])
            mem[i] = ERASED_WORD;
        pulseCnt = 5'h00;
        pulseAddr = '0;
        lastVal = 8'h00;
    end

    // ==========================================
    // read side, floating lines toggle each cycle
    assign driving = !pins.selectN && !pins.gateN && pins.program_strobe_n;

    always_comb
    begin
        if (dataOe)
            dataLine = dataOut;
        else if (driving && pins.id_access_address_pin)
            dataLine = pins.addr[ID_CODE_BIT] ? TYPE_CODE : MAKER_CODE;
        else if (driving)
            dataLine = mem[pins.addr];
        else
            dataLine = ~lastVal;
    end

    always @(posedge ref_clk)
        lastVal <= dataLine;

    // ==========================================
    // programming: only clears bits, only when selected
    always @(negedge pins.program_strobe_n)
        progData = dataLine;

    always @(posedge pins.program_strobe_n)
    begin
        if (pins.vppHigh === 1'b1 && pins.vccHigh === 1'b1 && pins.gateN === 1'b1
            && pins.selectN === 1'b0)
        begin
            pulseCnt = (pulseAddr == pins.addr) ? pulseCnt + 5'h01 : 5'h01;
            pulseAddr = pins.addr;
            if (pulseCnt >= needPulses)
                mem[pins.addr] = mem[pins.addr] & progData;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/epc_ctrl_tb.sv
// self-checking bench for the eprom programming controller
`timescale 1ns/1ps
`default_nettype none
module epc_ctrl_tb
    import epc_pkg::*;
;
    logic              refClk;
    logic              rst;
    logic              wbCyc;
    logic              wbStb;
    logic              wbWe;
    logic [3:0]        wbAdr;
    logic [3:0]        wbSel;
    logic [31:0]       wbDat;
    logic [31:0]       wbDatO;
    logic              wbAck;
    epc_pins_t         pins;
    logic [DATA_W-1:0] dataLine;
    logic [DATA_W-1:0] dataOut;
    logic              dataOe;
    logic [4:0]        needPulses;
    logic [31:0]       st;
    int                errors;
    int                checked;

    epc_ctrl dut (
        .ref_clk (refClk), .rst (rst), .wb_cyc_i (wbCyc), .wb_stb_i (wbStb),
        .wb_we_i (wbWe), .wb_adr_i (wbAdr), .wb_sel_i (wbSel), .wb_dat_i (wbDat),
        .wb_dat_o (wbDatO), .wb_ack_o (wbAck), .pins (pins), .data_in (dataLine),
        .data_out (dataOut), .data_oe (dataOe)
    );

    epc_mem_model u_mem (
        .ref_clk (refClk), .pins (pins), .dataOut (dataOut), .dataOe (dataOe),
        .needPulses (needPulses), .dataLine (dataLine)
    );

    initial
    begin
        refClk = 1'b0;
        forever #20 refClk = ~refClk;
    end

    // ==========================================
    // tasks
    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wbXfer(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        int n;
        @(posedge refClk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDat <= wd;
        wbSel <= 4'h3;
        n = 0;
        do
        begin
            @(posedge refClk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 16);
        st = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        if (n >= 16)
        begin
            errors++;
            results;
        end
    endtask

    task automatic waitDone;
        int n;
        n = 0;
        do
        begin
            wbXfer(1'b0, REG_STATUS, 32'h0);
            n++;
        end
        while ((st[ST_BUSY_BIT] !== 1'b0 || st[ST_DONE_BIT] !== 1'b1) && n < 20000);
        if (n >= 20000)
        begin
            errors++;
            results;
        end
    endtask

    task automatic runOp(input epc_op_t op, input logic [12:0] adr, input logic [7:0] wd);
        wbXfer(1'b1, REG_ADDR, {19'h0, adr});
        wbXfer(1'b1, REG_DATA, {24'h0, wd});
        wbXfer(1'b1, REG_CTRL, {29'h0, op, 1'b1});
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        errors = 0;
        checked = 0;
        rst = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 4'h0;
        wbSel = 4'h3;
        wbDat = 32'h0;
        needPulses = 5'h01;
        repeat (20) @(posedge refClk);
        check({pins.selectN, pins.gateN, pins.program_strobe_n, pins.vppHigh, dataOe}, 5'h1c);
        rst <= 1'b0;
        wbXfer(1'b0, 4'h2, 32'h0);
        check(st, 32'h0);
        runOp(OP_READ, 13'h1abc, 8'h00);
        waitDone;
        check({st[23:16], st[2]}, {8'hff, 1'b0});
        runOp(OP_PROGRAM, 13'h1abc, 8'h5a);
        waitDone;
        check({st[12:8], st[2]}, {5'h01, 1'b0});
        runOp(OP_READ, 13'h1abc, 8'h00);
        waitDone;
        check(st[23:16], 8'h5a);
        needPulses = 5'h02;
        runOp(OP_PROGRAM, 13'h0123, 8'h3c);
        wbXfer(1'b1, REG_ADDR, 32'h1abc);
        waitDone;
        check({st[12:8], st[2]}, {5'h02, 1'b0});
        wbXfer(1'b0, REG_ADDR, 32'h0);
        check(st, 32'h0000_0123);
        wbXfer(1'b0, REG_DATA, 32'h0);
        check(st, 32'h0000_003c);
        wbXfer(1'b1, REG_CTRL, {29'h0, OP_READ, 1'b1});
        waitDone;
        check(st[23:16], 8'h3c);
        runOp(OP_ID_MAKER, 13'h0000, 8'h00);
        waitDone;
        check(st[23:16], 8'h5a);
        runOp(OP_ID_TYPE, 13'h0000, 8'h00);
        waitDone;
        check(st[23:16], 8'h3c);
        results;
    end
endmodule
`default_nettype wire
